// File: rcr_map.svh
// Purpose: Register offsets, field positions and reset values of the reset cause recorder
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Shared by the package users and the design
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH

// Register byte offsets
`define RCR_OFS_FLAGS       12'h000
`define RCR_OFS_STATUS      12'h004
`define RCR_OFS_BO_CTRL     12'h008

// Reset cause flag positions
`define RCR_B_STK_OVF       7
`define RCR_B_STK_UNF       6
`define RCR_B_UNUSED        5
`define RCR_B_WDT           4
`define RCR_B_PIN           3
`define RCR_B_INSTR         2
`define RCR_B_POR           1
`define RCR_B_BROWNOUT      0

// CPU status flag positions
`define RCR_B_TIMEOUT       4
`define RCR_B_PWRDN         3

// Brown-out control positions
`define RCR_B_SBOREN        7
`define RCR_B_BORFS         6
`define RCR_B_BORRDY        0

// Reset values and masks
`define RCR_FLAGS_POR       8'h1c
`define RCR_FLAGS_WMASK     8'hdf
`define RCR_BO_CTRL_POR     8'h80
`define RCR_BO_CTRL_WMASK   8'hc0

// Program counter targets
`define RCR_RESET_VECTOR    16'h0000
`define RCR_IRQ_VECTOR      16'h0004

`endif

// File: rcr_pkg.sv
// Purpose: Types of the reset cause recorder
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in rcr_map.svh
package rcr_pkg;
  typedef logic [7:0]  rcr_reg_t;
  typedef logic [31:0] rcr_word_t;
  typedef logic [11:0] rcr_addr_t;
endpackage

// File: rcr_top.sv
// Purpose: Records reset and wake causes, loads the program counter after each reset or wake
// Assumes: Event inputs are one-cycle pulses synchronous to pclk; presetn is power-on reset
// Notes:   APB slave with zero wait states; registers at offsets 0x0, 0x4, 0x8
`include "rcr_map.svh"

module rcr_top #(
  parameter int PC_W = 15
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire rcr_pkg::rcr_addr_t    paddr,
  input  wire rcr_pkg::rcr_word_t    pwdata,
  output rcr_pkg::rcr_word_t         prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  bor_detect,
  input  wire logic                  lowpower_brownout,
  input  wire logic                  wdt_timeout,
  input  wire logic                  ext_pin_reset,
  input  wire logic                  reset_instr,
  input  wire logic                  stack_overflow,
  input  wire logic                  stack_underflow,
  input  wire logic                  irq_wake,
  input  wire logic                  sleeping,
  input  wire logic                  global_irq_enable,
  input  wire logic                  stack_fault_reset_enable,
  input  wire logic                  borrdy,
  input  wire logic [PC_W-1:0]       cur_pc,
  output logic                       pc_load,
  output logic [PC_W-1:0]            pc_value,
  output logic                       irq_vector_req,
  output logic                       core_reset,
  output logic                       timeout_bit_n,
  output logic                       powerdown_bit_n,
  output logic                       sw_bor_enable,
  output logic                       bor_fast_start
);
  import rcr_pkg::*;

  rcr_reg_t        flags;
  rcr_reg_t        next_flags;
  logic            next_tmo;
  logic            next_pwrdn;
  rcr_reg_t        boctl;
  rcr_word_t       next_rdata;

  // Bus decode
  wire             setup_ph   = psel & ~penable;
  wire             access_ph  = psel & penable;
  wire             hit_flags  = (paddr == `RCR_OFS_FLAGS);
  wire             hit_status = (paddr == `RCR_OFS_STATUS);
  wire             hit_boctl  = (paddr == `RCR_OFS_BO_CTRL);
  wire             hit_any    = hit_flags | hit_status | hit_boctl;
  wire             wr_flags   = access_ph & pwrite & hit_flags;
  wire             wr_boctl   = access_ph & pwrite & hit_boctl;

  // Event decode
  wire             brownout    = bor_detect | lowpower_brownout;
  wire             wdt_rst     = wdt_timeout & ~sleeping;
  wire             wdt_wake    = wdt_timeout & sleeping;
  wire             irq_wk      = irq_wake & sleeping;
  wire             stk_ovf_rst = stack_overflow & stack_fault_reset_enable;
  wire             stk_unf_rst = stack_underflow & stack_fault_reset_enable;
  wire             any_reset   = brownout | wdt_rst | ext_pin_reset | reset_instr
                                 | stk_ovf_rst | stk_unf_rst;
  wire             any_wake    = (wdt_wake | irq_wk) & ~any_reset;
  wire             irq_vec     = irq_wk & global_irq_enable & ~any_reset & ~wdt_wake;

  // Register read views
  wire rcr_reg_t   status_view = {3'b000, timeout_bit_n, powerdown_bit_n, 3'b000};
  wire rcr_reg_t   boctl_view  = {boctl[7:6], 5'b0_0000, borrdy};

  // Pass-through of the pc increment at controller width
  function automatic logic [PC_W-1:0] inc_pc(input logic [PC_W-1:0] pc);
    inc_pc = pc + PC_W'(1);
  endfunction

  // Next flag values: firmware write first, hardware events after so they win;
  // a reset in the same cycle keeps a wake from touching the status bits
  always_comb begin
    next_flags = flags;
    next_tmo   = timeout_bit_n;
    next_pwrdn = powerdown_bit_n;
    if (wr_flags) begin
      next_flags = pwdata[7:0] & `RCR_FLAGS_WMASK;
    end
    if (stk_ovf_rst) begin
      next_flags[`RCR_B_STK_OVF] = 1'b1;
    end
    if (stk_unf_rst) begin
      next_flags[`RCR_B_STK_UNF] = 1'b1;
    end
    if (reset_instr) begin
      next_flags[`RCR_B_INSTR] = 1'b0;
    end
    if (ext_pin_reset) begin
      next_flags[`RCR_B_PIN] = 1'b0;
      if (sleeping) begin
        next_tmo   = 1'b1;
        next_pwrdn = 1'b0;
      end
    end
    if (irq_wk && !any_reset) begin
      next_tmo   = 1'b1;
      next_pwrdn = 1'b0;
    end
    if (wdt_wake && !any_reset) begin
      next_tmo   = 1'b0;
      next_pwrdn = 1'b0;
    end
    if (wdt_rst) begin
      next_flags[`RCR_B_WDT] = 1'b0;
      next_tmo               = 1'b0;
    end
    if (brownout) begin
      next_flags[`RCR_B_STK_OVF]  = 1'b0;
      next_flags[`RCR_B_STK_UNF]  = 1'b0;
      next_flags[`RCR_B_PIN]      = 1'b1;
      next_flags[`RCR_B_INSTR]    = 1'b1;
      next_flags[`RCR_B_BROWNOUT] = 1'b0;
      next_tmo                    = 1'b1;
      next_pwrdn                  = 1'b1;
    end
  end

  // Read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_flags) begin
      next_rdata[7:0] = flags;
    end else if (hit_status) begin
      next_rdata[7:0] = status_view;
    end else if (hit_boctl) begin
      next_rdata[7:0] = boctl_view;
    end
  end

  // Flag and status registers; power-on loads the fixed pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags           <= `RCR_FLAGS_POR;
      timeout_bit_n   <= 1'b1;
      powerdown_bit_n <= 1'b1;
    end else begin
      flags           <= next_flags;
      timeout_bit_n   <= next_tmo;
      powerdown_bit_n <= next_pwrdn;
    end
  end

  // Brown-out control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boctl <= `RCR_BO_CTRL_POR;
    end else if (wr_boctl) begin
      boctl <= pwdata[7:0] & `RCR_BO_CTRL_WMASK;
    end
  end

  assign sw_bor_enable  = boctl[`RCR_B_SBOREN];
  assign bor_fast_start = boctl[`RCR_B_BORFS];

  // Program counter load after reset or wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load        <= 1'b1;
      pc_value       <= PC_W'(`RCR_RESET_VECTOR);
      irq_vector_req <= 1'b0;
      core_reset     <= 1'b1;
    end else begin
      pc_load        <= any_reset | any_wake;
      pc_value       <= any_reset ? PC_W'(`RCR_RESET_VECTOR) : inc_pc(cur_pc);
      irq_vector_req <= irq_vec;
      core_reset     <= any_reset;
    end
  end

  // APB answer: zero wait states, data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  assign pready  = access_ph;
  assign pslverr = access_ph & ~hit_any;

  // Checks
  property p_wdt_reset;
    @(posedge pclk) disable iff (!presetn)
    wdt_rst && !brownout |=> !flags[`RCR_B_WDT] && !timeout_bit_n
                             && powerdown_bit_n == $past(powerdown_bit_n);
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset not recorded");

  property p_pin_reset;
    @(posedge pclk) disable iff (!presetn)
    ext_pin_reset && !brownout |=> !flags[`RCR_B_PIN]
      ##1 !flags[`RCR_B_PIN] || $past(wr_flags) || $past(brownout);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset flag not cleared");

  property p_instr_reset;
    @(posedge pclk) disable iff (!presetn)
    reset_instr && wr_flags && !brownout |=> !flags[`RCR_B_INSTR];
  endproperty
  a_instr_reset: assert property (p_instr_reset) else $error("write beat hardware clear");

  property p_stack_ovf;
    @(posedge pclk) disable iff (!presetn)
    stack_overflow && stack_fault_reset_enable && !brownout
      |=> flags[`RCR_B_STK_OVF] && core_reset && pc_value == '0;
  endproperty
  a_stack_ovf: assert property (p_stack_ovf) else $error("stack overflow not recorded");

  property p_stack_gate;
    @(posedge pclk) disable iff (!presetn)
    (stack_overflow || stack_underflow) && !stack_fault_reset_enable && !brownout && !wdt_timeout
      && !ext_pin_reset && !reset_instr && !irq_wake && !wr_flags |=> $stable(flags) && !core_reset;
  endproperty
  a_stack_gate: assert property (p_stack_gate) else $error("stack fault acted while disabled");

  property p_reset_vector;
    @(posedge pclk) disable iff (!presetn)
    any_reset |=> pc_load && pc_value == PC_W'(`RCR_RESET_VECTOR) && !irq_vector_req;
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("reset did not load zero");

  property p_wdt_wake;
    @(posedge pclk) disable iff (!presetn)
    wdt_wake && !any_reset && !wr_flags
      |=> !timeout_bit_n && !powerdown_bit_n && $stable(flags)
          && pc_value == inc_pc($past(cur_pc));
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake mishandled");

  property p_irq_wake;
    @(posedge pclk) disable iff (!presetn)
    irq_wk && !any_reset && !wdt_wake && !wr_flags
      |=> timeout_bit_n && !powerdown_bit_n && $stable(flags)
          && irq_vector_req == $past(global_irq_enable);
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake mishandled");

  property p_brownout;
    @(posedge pclk) disable iff (!presetn)
    (bor_detect || lowpower_brownout)
      |=> flags[7:6] == 2'b00 && flags[`RCR_B_BROWNOUT] == 1'b0 && flags[3:2] == 2'b11
          && timeout_bit_n && powerdown_bit_n && core_reset;
  endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out pattern wrong");

  property p_unused_bit;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && hit_flags && !pwrite |-> prdata[`RCR_B_UNUSED] == 1'b0;
  endproperty
  a_unused_bit: assert property (p_unused_bit) else $error("bit five read non-zero");

  property p_por_never_set;
    @(posedge pclk) disable iff (!presetn)
    !flags[`RCR_B_POR] && !wr_flags |=> !flags[`RCR_B_POR];
  endproperty
  a_por_never_set: assert property (p_por_never_set) else $error("power-on flag set by hw");

endmodule

// File: rcr_core_model.sv
// Purpose: Stand-in for the processor core that the recorder steers
// Assumes: pc_load and irq_vector_req are one-cycle pulses
// Notes:   Vectoring to the interrupt address is the core's job
`include "rcr_map.svh"

module rcr_core_model #(
  parameter int PC_W = 15
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            sleeping,
  input  wire logic            pc_load,
  input  wire logic [PC_W-1:0] pc_value,
  input  wire logic            irq_vector_req,
  output logic      [PC_W-1:0] cur_pc
);
  logic vec_pending;

  // Load on request, vector one instruction later, else step while awake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_pc <= '0;
      vec_pending <= 1'h0;
    end else if (pc_load) begin
      cur_pc <= pc_value;
      vec_pending <= irq_vector_req;
    end else if (vec_pending) begin
      cur_pc <= PC_W'(`RCR_IRQ_VECTOR);
      vec_pending <= 1'h0;
    end else if (!sleeping) begin
      cur_pc <= cur_pc + 1'h1;
    end
  end
endmodule

// File: reset_cause_recorder_bench.sv
// Purpose: Self-checking bench of the reset cause recorder
// Assumes: Zero-wait APB slave, one-cycle event pulses
// Notes:   The core side is played by rcr_core_model
`include "rcr_map.svh"

module reset_cause_recorder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rcr_pkg::*;
  logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic       irq_en, sfre, borrdy, sleeping, pc_load, irq_vector_req, core_reset;
  logic       timeout_bit_n, powerdown_bit_n, sw_bor_enable, bor_fast_start;
  logic [7:0] ev;
  logic [14:0] cur_pc, pc_value;
  rcr_addr_t  paddr;
  rcr_word_t  pwdata, prdata, rd;
  int         bad_count, total_checks;

  rcr_top #(.PC_W(15)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bor_detect(ev[0]),
    .lowpower_brownout(ev[1]), .wdt_timeout(ev[2]), .ext_pin_reset(ev[3]),
    .reset_instr(ev[4]), .stack_overflow(ev[5]), .stack_underflow(ev[6]),
    .irq_wake(ev[7]), .sleeping(sleeping), .global_irq_enable(irq_en),
    .stack_fault_reset_enable(sfre), .borrdy(borrdy), .cur_pc(cur_pc),
    .pc_load(pc_load), .pc_value(pc_value), .irq_vector_req(irq_vector_req),
    .core_reset(core_reset), .timeout_bit_n(timeout_bit_n),
    .powerdown_bit_n(powerdown_bit_n), .sw_bor_enable(sw_bor_enable),
    .bor_fast_start(bor_fast_start));

  rcr_core_model #(.PC_W(15)) core (.pclk(pclk), .presetn(presetn),
    .sleeping(sleeping), .pc_load(pc_load), .pc_value(pc_value),
    .irq_vector_req(irq_vector_req), .cur_pc(cur_pc));

  // Free-running system clock
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input rcr_addr_t a, input rcr_word_t d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic rdchk(input rcr_addr_t a, input logic [7:0] exp, input string what);
    apb(1'h0, a, 32'h0000_0000);
    chk(what, {24'h00_0000, exp}, rd);
  endtask

  // Fire one event, then judge core outputs and both flag registers
  task automatic ev_chk(input int idx, input logic wake, input logic [7:0] ef,
                        input logic [7:0] es, input logic [2:0] eo);
    logic [14:0] pc0;
    @(posedge pclk);
    ev[idx] <= 1'h1;
    #1;
    pc0 = cur_pc; // Core PC as the recorder samples it with the event
    @(posedge pclk);
    ev <= 8'h00;
    #1;
    chk("core outputs", {29'h0000_0000, eo}, {29'h0000_0000, core_reset, pc_load, irq_vector_req});
    if (pc_load === 1'h1)
      chk("pc_value", wake ? {17'h0_0000, pc0 + 15'h0001} : 32'h0000_0000, {17'h0_0000, pc_value});
    chk("status pins", {30'h0000_0000, es[`RCR_B_TIMEOUT], es[`RCR_B_PWRDN]},
        {30'h0000_0000, timeout_bit_n, powerdown_bit_n});
    @(posedge pclk);
    #1;
    chk("pulse end", 32'h0000_0000, {29'h0000_0000, core_reset, pc_load, irq_vector_req});
    rdchk(`RCR_OFS_FLAGS, ef, "flags");
    rdchk(`RCR_OFS_STATUS, es, "status");
  endtask

  task automatic t_por();
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (12) @(posedge pclk);
    chk("reset outputs", 32'h0000_0003, {30'h0000_0000, core_reset, pc_load});
    presetn <= 1'h1;
    rdchk(`RCR_OFS_FLAGS, 8'h1c, "flags");
    rdchk(`RCR_OFS_STATUS, 8'h18, "status");
    rdchk(`RCR_OFS_BO_CTRL, 8'h81, "brownout control");
  endtask

  task automatic t_rearm();
    apb(1'h1, `RCR_OFS_FLAGS, 32'h0000_00ff);
    rdchk(`RCR_OFS_FLAGS, 8'hdf, "flags");
    apb(1'h1, `RCR_OFS_STATUS, 32'h0000_0000);
    rdchk(`RCR_OFS_STATUS, 8'h18, "status");
    apb(1'h1, `RCR_OFS_BO_CTRL, 32'h0000_007f);
    rdchk(`RCR_OFS_BO_CTRL, 8'h41, "brownout control");
    chk("bor outs", 32'h0000_0001, {30'h0000_0000, sw_bor_enable, bor_fast_start});
    apb(1'h0, 12'h00c, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
  endtask

  task automatic t_awake();
    ev_chk(2, 1'h0, 8'hcf, 8'h08, 3'h6);
    ev_chk(3, 1'h0, 8'hc7, 8'h08, 3'h6);
    ev_chk(4, 1'h0, 8'hc3, 8'h08, 3'h6);
    ev_chk(7, 1'h0, 8'hc3, 8'h08, 3'h0);
  endtask

  task automatic t_stack();
    apb(1'h1, `RCR_OFS_FLAGS, 32'h0000_001f);
    ev_chk(5, 1'h0, 8'h1f, 8'h08, 3'h0);
    sfre <= 1'h1;
    ev_chk(5, 1'h0, 8'h9f, 8'h08, 3'h6);
    ev_chk(6, 1'h0, 8'hdf, 8'h08, 3'h6);
  endtask

  task automatic t_sleep();
    sleeping <= 1'h1;
    ev_chk(2, 1'h1, 8'hdf, 8'h00, 3'h2);
    ev_chk(7, 1'h1, 8'hdf, 8'h10, 3'h3);
    ev_chk(2, 1'h1, 8'hdf, 8'h00, 3'h2);
    ev_chk(3, 1'h0, 8'hd7, 8'h10, 3'h6);
    sleeping <= 1'h0;
  endtask

  task automatic t_brown();
    ev_chk(1, 1'h0, 8'h1e, 8'h18, 3'h6);
    apb(1'h1, `RCR_OFS_FLAGS, 32'h0000_00c5);
    ev_chk(0, 1'h0, 8'h0c, 8'h18, 3'h6);
  endtask

  // Flag write and hardware events sampled at the same access edge
  task automatic t_clash();
    fork
      apb(1'h1, `RCR_OFS_FLAGS, 32'h0000_001f);
      begin
        repeat (2) @(posedge pclk);
        ev[4] <= 1'h1;
        ev[5] <= 1'h1;
        @(posedge pclk);
        ev <= 8'h00;
      end
    join
    rdchk(`RCR_OFS_FLAGS, 8'h9b, "flags");
  endtask

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev} = '0;
    {irq_en, sfre, borrdy, sleeping, presetn} = 5'h14;
    bad_count = 0;
    total_checks = 0;
    t_por();
    t_rearm();
    t_awake();
    t_stack();
    t_sleep();
    t_brown();
    t_clash();
    t_por();
    tally_and_finish();
  end
endmodule
